// *** inc/sdram_pm_pkg.sv ***
// Package with offsets, fields, reset values and types of the SDRAM power manager.
// Behaviour
// - Stop SDRAM clock when idle count exceeds threshold.
// - Access during clock stop restarts after three cycles.
// - Threshold two means stop after three idle cycles.
// - Self-refresh only by software commands.
// - Command code 110 enters self-refresh when running or clock-stopped; it is ignored during the clock restart.
// - Command code 111 leaves self-refresh.
// - No auto refresh, clock held stopped in self-refresh.
// - Clock resumes after cancel command accepted.
// - DRAM accesses during self-refresh get abort error.
package sdram_pm_pkg;
	localparam logic [3:0]  threshold_off     = 4'h0;
	localparam logic [3:0]  control_off       = 4'h4;
	localparam logic [3:0]  command_off       = 4'h8;
	localparam logic [3:0]  status_off        = 4'hc;
	localparam logic [3:0]  irq_status_off    = 4'h0 + 4'h0 + 4'h0;
	localparam logic [7:0]  irq_status_addr   = 8'h10;
	localparam logic [7:0]  irq_mask_addr     = 8'h14;
	localparam int          enable_bit        = 0;
	localparam int          cmd_lsb           = 0;
	localparam logic [2:0]  cmd_sr_start      = 3'h6;
	localparam logic [2:0]  cmd_sr_cancel     = 3'h7;
	localparam logic [15:0] threshold_rst     = 16'h0000;
	localparam int          restore_ns        = 60;
	localparam int          clk_period_ns     = 20;
	localparam logic [1:0]  restore_cycles    = 2'(restore_ns / clk_period_ns);
	localparam int          irq_pd_entry      = 0;
	localparam int          irq_pd_exit       = 1;
	localparam int          irq_sr_abort      = 2;
	localparam int          irq_width         = 3;

	typedef enum logic [1:0] {st_run, st_pdown, st_wake, st_selfref} pm_state_type;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} reg_req_type;

	typedef struct packed {
		logic req;
		logic slot;
	} mem_req_type;
endpackage

// *** hw/sdram_power_manager.sv ***
// SDRAM power manager: automatic clock-stop power-down and software self-refresh.
module sdram_power_manager
	import sdram_pm_pkg::*;
(
	// Clock and reset.
	input  wire logic                        core_clk_i,
	input  wire logic                        sys_rst_i,
	// Register port.
	input  wire sdram_pm_pkg::reg_req_type   reg_req_i,
	output logic [31:0]                      reg_rdata_o,
	// DRAM space accesses from the bus side.
	input  wire sdram_pm_pkg::mem_req_type   mem_i,
	output logic                             mem_ready_o,
	output logic                             mem_abort_o,
	// Refresh and SDRAM clock control.
	input  wire logic                        refresh_tick_i,
	output logic                             auto_refresh_o,
	output logic                             sdram_clock_out_en_o,
	output logic                             self_refresh_o,
	// Interrupt.
	output logic                             irq_o
);
	import sdram_pm_pkg::*;

	pm_state_type           state_q;
	pm_state_type           state_d;
	logic [15:0]            powerdown_threshold_reg_q;
	logic                   auto_powerdown_enable_q;
	logic [15:0]            idle_q;
	logic [15:0]            idle_d;
	logic [1:0]             wake_q;
	logic [1:0]             wake_d;
	logic [irq_width-1:0]   irq_stat_q;
	logic [irq_width-1:0]   irq_mask_q;
	logic [irq_width-1:0]   irq_evt;
	logic [31:0]            rdata_q;
	logic                   mem_abort_q;
	wire                    wr_thr;
	wire                    wr_ctl;
	wire                    wr_cmd;
	wire                    wr_ist;
	wire                    wr_imsk;
	wire                    cmd_start;
	wire                    cmd_cancel;
	wire                    over_thr;
	wire  [31:0]            rd_mux;

	assign wr_thr     = reg_req_i.wr && (reg_req_i.addr == {4'h0, threshold_off});
	assign wr_ctl     = reg_req_i.wr && (reg_req_i.addr == {4'h0, control_off});
	assign wr_cmd     = reg_req_i.wr && (reg_req_i.addr == {4'h0, command_off});
	assign wr_ist     = reg_req_i.wr && (reg_req_i.addr == irq_status_addr);
	assign wr_imsk    = reg_req_i.wr && (reg_req_i.addr == irq_mask_addr);
	// Only software commands move self-refresh; no timer can start it.
	assign cmd_start  = wr_cmd && (reg_req_i.wdata[cmd_lsb+:3] == cmd_sr_start);
	assign cmd_cancel = wr_cmd && (reg_req_i.wdata[cmd_lsb+:3] == cmd_sr_cancel);
	// Strictly greater: threshold two stops after the third idle slot.
	assign over_thr   = idle_q > powerdown_threshold_reg_q;

	always_comb begin
		state_d = state_q;
		idle_d  = idle_q;
		wake_d  = wake_q;
		case (state_q)
			st_run: begin
				if (cmd_start) begin
					state_d = st_selfref;
				end else if (!auto_powerdown_enable_q || mem_i.req) begin
					idle_d = 16'h0000;
				end else if (over_thr) begin
					state_d = st_pdown;
				end else if (mem_i.slot) begin
					idle_d = idle_q + 16'h0001;
				end
			end
			st_pdown: begin
				idle_d = 16'h0000;
				if (cmd_start) begin
					state_d = st_selfref;
				end else if (mem_i.req || !auto_powerdown_enable_q) begin
					state_d = st_wake;
					wake_d  = restore_cycles - 2'h1;
				end
			end
			st_wake: begin
				idle_d = 16'h0000;
				if (wake_q == 2'h0) begin
					state_d = st_run;
				end else begin
					wake_d = wake_q - 2'h1;
				end
			end
			st_selfref: begin
				idle_d = 16'h0000;
				if (cmd_cancel) begin
					state_d = st_run;
				end
			end
			default: begin
				state_d = st_run;
			end
		endcase
	end

	// Sets win over write-one clears so no event is lost.
	assign irq_evt = {mem_abort_o, (state_q == st_pdown) && (state_d != st_pdown),
		(state_q == st_run) && (state_d == st_pdown)};

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state_q                   <= st_run;
			idle_q                    <= 16'h0000;
			wake_q                    <= 2'h0;
			powerdown_threshold_reg_q <= threshold_rst;
			auto_powerdown_enable_q   <= 1'b0;
			irq_stat_q                <= '0;
			irq_mask_q                <= '0;
			rdata_q                   <= 32'h0000_0000;
			mem_abort_q               <= 1'b0;
		end else begin
			state_q     <= state_d;
			idle_q      <= idle_d;
			wake_q      <= wake_d;
			rdata_q     <= reg_req_i.rd ? rd_mux : 32'h0000_0000;
			mem_abort_q <= mem_i.req && (state_q == st_selfref);
			irq_stat_q  <= (irq_stat_q & ~(wr_ist ? reg_req_i.wdata[irq_width-1:0] : '0))
				| irq_evt;
			if (wr_thr) begin
				powerdown_threshold_reg_q <= reg_req_i.wdata[15:0];
			end
			// Enable is honoured whenever written; threshold order is software's duty.
			if (wr_ctl) begin
				auto_powerdown_enable_q <= reg_req_i.wdata[enable_bit];
			end
			if (wr_imsk) begin
				irq_mask_q <= reg_req_i.wdata[irq_width-1:0];
			end
		end
	end

	assign rd_mux =
		(reg_req_i.addr == {4'h0, threshold_off}) ? {16'h0000, powerdown_threshold_reg_q} :
		(reg_req_i.addr == {4'h0, control_off})   ? {31'h0, auto_powerdown_enable_q} :
		(reg_req_i.addr == {4'h0, status_off})    ? {29'h0, state_q == st_selfref,
			state_q == st_pdown, state_q == st_wake} :
		(reg_req_i.addr == irq_status_addr)       ? {29'h0, irq_stat_q} :
		(reg_req_i.addr == irq_mask_addr)         ? {29'h0, irq_mask_q} : 32'h0000_0000;

	assign reg_rdata_o          = rdata_q;
	assign mem_abort_o          = mem_abort_q;
	// Accesses stall while the clock is stopped or restarting.
	assign mem_ready_o          = (state_q == st_run) && !cmd_start;
	assign sdram_clock_out_en_o = (state_q == st_run) || (state_q == st_wake);
	assign auto_refresh_o       = refresh_tick_i && (state_q != st_selfref);
	assign self_refresh_o       = state_q == st_selfref;
	assign irq_o                = |(irq_stat_q & irq_mask_q);
endmodule

// *** dv/sdram_pm_sva.sv ***
// Checker for the SDRAM power manager ports.
module sdram_pm_sva
	import sdram_pm_pkg::*;
(
	input wire logic                      core_clk_i,
	input wire logic                      sys_rst_i,
	input wire sdram_pm_pkg::reg_req_type reg_req_i,
	input wire sdram_pm_pkg::mem_req_type mem_i,
	input wire logic                      mem_ready_o,
	input wire logic                      mem_abort_o,
	input wire logic                      auto_refresh_o,
	input wire logic                      sdram_clock_out_en_o,
	input wire logic                      self_refresh_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	wire cmd_w = reg_req_i.wr && reg_req_i.addr == 8'(command_off);
	wire [2:0] code_w = reg_req_i.wdata[2:0];
	chk_sr_quiet: assert property (self_refresh_o
		|-> !auto_refresh_o && !sdram_clock_out_en_o) else $error("refresh or clock in self-refresh");
	chk_sr_enter: assert property (cmd_w && code_w == cmd_sr_start |=> self_refresh_o)
		else $error("start command ignored");
	chk_sr_leave: assert property (self_refresh_o && cmd_w && code_w == cmd_sr_cancel
		|=> !self_refresh_o && sdram_clock_out_en_o) else $error("cancel command ignored");
	chk_sr_cause: assert property ($rose(self_refresh_o) |-> $past(cmd_w))
		else $error("self-refresh without command");
	chk_abort_seen: assert property (self_refresh_o && mem_i.req |=> mem_abort_o)
		else $error("access not aborted");
	chk_abort_cause: assert property (mem_abort_o
		|-> $past(mem_i.req) && $past(self_refresh_o)) else $error("abort without cause");
	chk_wake_len: assert property (mem_i.req && !sdram_clock_out_en_o && !self_refresh_o
		|=> (sdram_clock_out_en_o && !mem_ready_o)[*3] ##1 mem_ready_o) else $error("wake length");
	chk_pd_idle: assert property ($fell(sdram_clock_out_en_o) && !self_refresh_o
		|-> !$past(mem_i.req)) else $error("clock stopped while busy");
endmodule
bind sdram_power_manager sdram_pm_sva u_sva (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
	.reg_req_i(reg_req_i), .mem_i(mem_i), .mem_ready_o(mem_ready_o), .mem_abort_o(mem_abort_o),
	.auto_refresh_o(auto_refresh_o), .sdram_clock_out_en_o(sdram_clock_out_en_o),
	.self_refresh_o(self_refresh_o));

// *** dv/sdram_model.sv ***
// Behavioural SDRAM partner that passes one access slot per running clock cycle.
module sdram_model (
	input  wire logic clk_i,
	input  wire logic clk_en_i,
	input  wire logic auto_refresh_i,
	output logic      slot_o,
	output logic      fault_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// No slot can pass while the clock is stopped, so idle time only counts when running.
	assign slot_o = clk_en_i;
	initial fault_o = 1'b0;
	// A refresh sent with a stopped clock would be lost by a real part.
	always @(posedge clk_i) if (auto_refresh_i && !clk_en_i) fault_o <= 1'b1;
endmodule

// *** dv/sdram_power_manager_bench.sv ***
// Self-checking bench for the SDRAM power manager.
module sdram_power_manager_bench import sdram_pm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i = 1'b0, sys_rst_i = 1'b1, acc = 1'b0, tick = 1'b0;
	logic slot, fault, ready, abort, refr, clk_en, sref, irq;
	logic [31:0] rdata;
	reg_req_type req = '0;
	wire mem_req_type mem_w = {acc, slot};
	int fail_count = 0, checks = 0;
	always #10 core_clk_i = ~core_clk_i;
	sdram_power_manager dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(req),
		.reg_rdata_o(rdata), .mem_i(mem_w), .mem_ready_o(ready), .mem_abort_o(abort),
		.refresh_tick_i(tick), .auto_refresh_o(refr), .sdram_clock_out_en_o(clk_en),
		.self_refresh_o(sref), .irq_o(irq));
	sdram_model mdl (.clk_i(core_clk_i), .clk_en_i(clk_en), .auto_refresh_i(refr),
		.slot_o(slot), .fault_o(fault));
	task finish_test;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic c);
		checks++;
		if (c !== 1'b1) begin
			fail_count++;
			$display("mismatch %0t check %0d", $time, checks);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i) req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge core_clk_i) req <= '0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk_i) req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
		@(posedge core_clk_i) req <= '0;
		#1 chk(rdata === e);
	endtask
	task irq_is(input logic v);
		@(posedge core_clk_i);
		#1 chk(irq === v);
	endtask
	task t_pd;
		int n;
		wr(8'h00, 32'h2);
		wr(8'h04, 32'h1);
		repeat (2) @(posedge core_clk_i);
		#1 chk(clk_en === 1'b1);
		n = 0;
		while (clk_en !== 1'b0 && n < 8) begin
			@(posedge core_clk_i);
			#1 n++;
		end
		// Running out of the bound counts as a mismatch before the report.
		if (n == 8) begin
			fail_count++;
			finish_test;
		end
		chk(n === 2);
		@(posedge core_clk_i) acc <= 1'b1;
		n = 0;
		repeat (8) begin
			@(posedge core_clk_i);
			#1 if (ready !== 1'b1) n++;
		end
		chk(n === 3 && ready === 1'b1 && clk_en === 1'b1);
		rd(8'h10, 32'h3);
		irq_is(1'b0);
		wr(8'h14, 32'h1);
		irq_is(1'b1);
		wr(8'h10, 32'h3);
		irq_is(1'b0);
	endtask
	task t_sr;
		@(posedge core_clk_i) acc <= 1'b0;
		tick <= 1'b1;
		#1 chk(refr === 1'b1);
		wr(8'h08, 32'h6);
		#1 chk(sref === 1'b1 && clk_en === 1'b0 && refr === 1'b0);
		repeat (20) begin
			@(posedge core_clk_i);
			#1 chk(sref === 1'b1 && clk_en === 1'b0);
		end
		rd(8'h0c, 32'h4);
		@(posedge core_clk_i) acc <= 1'b1;
		@(posedge core_clk_i) acc <= 1'b0;
		#1 chk(abort === 1'b1);
		wr(8'h08, 32'h7);
		#1 chk(sref === 1'b0 && clk_en === 1'b1 && refr === 1'b1);
		rd(8'h10, 32'h4);
		rd(8'h20, 32'h0);
		chk(fault === 1'b0);
		@(posedge core_clk_i) tick <= 1'b0;
	endtask
	initial begin
		repeat (2) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		t_pd;
		t_sr;
		finish_test;
	end
endmodule
